// ---- design/tss_pkg.sv ----
// Constants shared by the sensor state sequencer
package tss_pkg;

  // Register offsets
  localparam logic [15:0] ADDR_CHIP_STANDBY = 16'h1000;
  localparam logic [15:0] ADDR_STREAM_MODE = 16'h1001;
  localparam logic [15:0] ADDR_ILLUM_TYPE = 16'h10e2;
  localparam logic [15:0] ADDR_PAT_NUM_HIGH = 16'h1405;
  localparam logic [15:0] ADDR_PAT_NUM_LOW = 16'h1406;
  localparam logic [15:0] ADDR_PAT_ON = 16'h1407;
  localparam logic [15:0] ADDR_LED_CTRL = 16'h21c4;

  // Field positions and values
  localparam int unsigned BIT_CTRL = 0;
  localparam logic [8:0] PAT_NUM_PN9 = 9'h004;
  localparam logic [7:0] LED_CTRL_OFF = 8'h00;
  localparam logic [7:0] LED_CTRL_ON = 8'hff;

  // Reset values
  localparam logic [7:0] RST_CHIP_STANDBY = 8'h01;
  localparam logic [7:0] RST_STREAM_MODE = 8'h00;
  localparam logic [7:0] RST_ILLUM_TYPE = 8'h00;
  localparam logic [7:0] RST_PAT_NUM_HIGH = 8'h00;
  localparam logic [7:0] RST_PAT_NUM_LOW = 8'h00;
  localparam logic [7:0] RST_PAT_ON = 8'h00;
  localparam logic [7:0] RST_LED_CTRL = 8'h00;
  localparam logic [8:0] PRBS_SEED = 9'h1ff;

  // Timing
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned FIRST_OUT_MAX_US = 600;
  localparam int unsigned FIRST_OUT_MAX_CYC = FIRST_OUT_MAX_US * CLK_KHZ / 1000;
  localparam int unsigned OTP_LOAD_EDGES = 64;
  localparam int unsigned WAKE_CYC = 1000;
  localparam int unsigned INTEG_CYC = 2000;
  localparam int unsigned READ_CYC = 2000;
  localparam int unsigned SYNC_BITS = 3;

  typedef enum logic [6:0] {
    ST_HW_STANDBY   = 7'h01,
    ST_OTP_LOAD     = 7'h02,
    ST_CHIP_STANDBY = 7'h04,
    ST_SW_STANDBY   = 7'h08,
    ST_WAKEUP       = 7'h10,
    ST_WAIT_VSYNC   = 7'h20,
    ST_FRAME        = 7'h40
  } tss_state_t;

endpackage

// ---- design/tss_pat_if.sv ----
// Link between the sequencer and its pattern generator
`timescale 1ns/1ps
`default_nettype none
interface tss_pat_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic restart;
  logic advance;
  logic [8:0] data;

  modport ctrl (input clk, input rst_n, output restart, output advance,
    input data);
  modport gen (input clk, input rst_n, input restart, input advance,
    output data);
endinterface
`default_nettype wire

// ---- design/tss_prbs9.sv ----
// Nine-stage pseudo-random pattern generator
`timescale 1ns/1ps
`default_nettype none
module tss_prbs9 (
  tss_pat_if.gen pat
);
  logic [8:0] lfsr_reg;
  logic [8:0] lfsr_next;

  // Taps for x^9 + x^5 + 1
  assign lfsr_next = pat.restart ? tss_pkg::PRBS_SEED :
    pat.advance ? {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]} :
    lfsr_reg;
  assign pat.data = lfsr_reg;

  always_ff @(posedge pat.clk or negedge pat.rst_n) begin
    if (!pat.rst_n) begin
      lfsr_reg <= tss_pkg::PRBS_SEED;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  prbs_step_a: assert property (@(posedge pat.clk) disable iff (!pat.rst_n)
    pat.advance && !pat.restart |=> lfsr_reg ==
    {$past(lfsr_reg[7:0]), $past(lfsr_reg[8]) ^ $past(lfsr_reg[4])})
    else $error("pattern step breaks the shift sequence");
  prbs_nonzero_a: assert property (@(posedge pat.clk)
    disable iff (!pat.rst_n) lfsr_reg != 9'h000)
    else $error("pattern register locked at zero");
endmodule // tss_prbs9
`default_nettype wire

// ---- design/tss_top.sv ----
// Startup, standby and streaming sequencer of the sensor
`timescale 1ns/1ps
`default_nettype none
module tss_top #(
  parameter int unsigned WAKE_CYC = tss_pkg::WAKE_CYC,
  parameter int unsigned INTEG_CYC = tss_pkg::INTEG_CYC,
  parameter int unsigned READ_CYC = tss_pkg::READ_CYC,
  parameter int unsigned FIRST_OUT_MAX_CYC = tss_pkg::FIRST_OUT_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ext_reset_n,
  input wire logic input_clock_pin,
  input wire logic vertical_sync_pin,
  input wire logic timing_master,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic [11:0] pix_in,
  input wire logic illum_mod,
  output logic [11:0] pix_out,
  output logic pix_valid,
  output logic frame_start,
  output logic frame_active,
  output logic led_driver_enable,
  output logic illum_out_pos,
  output logic illum_out_neg,
  output logic otp_busy,
  output logic chip_standby,
  output logic sw_standby,
  output logic streaming
);
  localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYC - 1);
  localparam logic [15:0] INTEG_END = 16'(INTEG_CYC);
  localparam logic [15:0] FRAME_LAST = 16'(INTEG_CYC + READ_CYC - 1);
  localparam logic [15:0] OTP_LAST = 16'(tss_pkg::OTP_LOAD_EDGES - 1);
  localparam int unsigned SB = tss_pkg::SYNC_BITS;
  localparam int unsigned B = tss_pkg::BIT_CTRL;

  // Pin synchronisers: reset pin, input clock pin, vertical sync pin
  logic [SB-1:0] pins;
  logic [SB-1:0] sync1_reg;
  logic [SB-1:0] sync2_reg;
  logic [SB-1:0] prev_reg;
  assign pins = {vertical_sync_pin, input_clock_pin, ext_reset_n};

  genvar gi;
  generate
    for (gi = 0; gi < SB; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  logic ext_ok;
  logic clk_rise;
  logic vs_fall;
  assign ext_ok = sync2_reg[0];
  assign clk_rise = sync2_reg[1] && !prev_reg[1];
  assign vs_fall = !sync2_reg[2] && prev_reg[2];

  tss_pkg::tss_state_t state_reg;
  tss_pkg::tss_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0] standby_reg;
  logic [7:0] mode_reg;
  logic [7:0] illum_reg;
  logic [7:0] pat_hi_reg;
  logic [7:0] pat_lo_reg;
  logic [7:0] pat_on_reg;
  logic [7:0] led_ctrl_reg;

  // Register write decode
  logic wr_allowed;
  logic wr_go;
  logic wr_standby;
  logic wr_mode;
  logic wr_illum;
  logic wr_pat_hi;
  logic wr_pat_lo;
  logic wr_pat_on;
  logic wr_led;
  // No access while in hardware standby or loading one-time data
  assign wr_allowed = (state_reg != tss_pkg::ST_HW_STANDBY) &&
    (state_reg != tss_pkg::ST_OTP_LOAD) && ext_ok;
  assign wr_go = reg_wr && wr_allowed;
  assign wr_standby = wr_go && reg_addr == tss_pkg::ADDR_CHIP_STANDBY;
  assign wr_mode = wr_go && reg_addr == tss_pkg::ADDR_STREAM_MODE;
  assign wr_illum = wr_go && reg_addr == tss_pkg::ADDR_ILLUM_TYPE;
  assign wr_pat_hi = wr_go && reg_addr == tss_pkg::ADDR_PAT_NUM_HIGH;
  assign wr_pat_lo = wr_go && reg_addr == tss_pkg::ADDR_PAT_NUM_LOW;
  assign wr_pat_on = wr_go && reg_addr == tss_pkg::ADDR_PAT_ON;
  assign wr_led = wr_go && reg_addr == tss_pkg::ADDR_LED_CTRL;

  // External reset pin returns every register to its default
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      standby_reg <= tss_pkg::RST_CHIP_STANDBY;
      mode_reg <= tss_pkg::RST_STREAM_MODE;
      illum_reg <= tss_pkg::RST_ILLUM_TYPE;
      pat_hi_reg <= tss_pkg::RST_PAT_NUM_HIGH;
      pat_lo_reg <= tss_pkg::RST_PAT_NUM_LOW;
      pat_on_reg <= tss_pkg::RST_PAT_ON;
      led_ctrl_reg <= tss_pkg::RST_LED_CTRL;
    end else if (!ext_ok) begin
      standby_reg <= tss_pkg::RST_CHIP_STANDBY;
      mode_reg <= tss_pkg::RST_STREAM_MODE;
      illum_reg <= tss_pkg::RST_ILLUM_TYPE;
      pat_hi_reg <= tss_pkg::RST_PAT_NUM_HIGH;
      pat_lo_reg <= tss_pkg::RST_PAT_NUM_LOW;
      pat_on_reg <= tss_pkg::RST_PAT_ON;
      led_ctrl_reg <= tss_pkg::RST_LED_CTRL;
    end else begin
      if (wr_standby) standby_reg <= reg_wdata;
      if (wr_mode) mode_reg <= reg_wdata;
      if (wr_illum) illum_reg <= reg_wdata;
      if (wr_pat_hi) pat_hi_reg <= reg_wdata;
      if (wr_pat_lo) pat_lo_reg <= reg_wdata;
      if (wr_pat_on) pat_on_reg <= reg_wdata;
      if (wr_led) led_ctrl_reg <= reg_wdata;
    end
  end

  // Read mux; unmapped offsets and blocked reads answer zero
  logic [7:0] rd_mux;
  assign rd_mux = !wr_allowed ? 8'h00 :
    reg_addr == tss_pkg::ADDR_CHIP_STANDBY ? standby_reg :
    reg_addr == tss_pkg::ADDR_STREAM_MODE ? mode_reg :
    reg_addr == tss_pkg::ADDR_ILLUM_TYPE ? illum_reg :
    reg_addr == tss_pkg::ADDR_PAT_NUM_HIGH ? pat_hi_reg :
    reg_addr == tss_pkg::ADDR_PAT_NUM_LOW ? pat_lo_reg :
    reg_addr == tss_pkg::ADDR_PAT_ON ? pat_on_reg :
    reg_addr == tss_pkg::ADDR_LED_CTRL ? led_ctrl_reg : 8'h00;

  logic standby_bit;
  logic stream_bit;
  logic frame_last;
  assign standby_bit = standby_reg[B];
  assign stream_bit = mode_reg[B];
  assign frame_last = state_reg == tss_pkg::ST_FRAME && cnt_reg == FRAME_LAST;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tss_pkg::ST_HW_STANDBY: begin
        state_next = tss_pkg::ST_OTP_LOAD;
      end
      tss_pkg::ST_OTP_LOAD: begin
        if (clk_rise && cnt_reg == OTP_LAST) begin
          state_next = tss_pkg::ST_CHIP_STANDBY;
        end
      end
      tss_pkg::ST_CHIP_STANDBY: begin
        if (!standby_bit) begin
          state_next = tss_pkg::ST_SW_STANDBY;
        end
      end
      tss_pkg::ST_SW_STANDBY: begin
        if (standby_bit) begin
          state_next = tss_pkg::ST_CHIP_STANDBY;
        end else if (stream_bit) begin
          state_next = tss_pkg::ST_WAKEUP;
        end
      end
      tss_pkg::ST_WAKEUP: begin
        if (cnt_reg == WAKE_LAST) begin
          state_next = timing_master ? tss_pkg::ST_FRAME :
            tss_pkg::ST_WAIT_VSYNC;
        end
      end
      tss_pkg::ST_WAIT_VSYNC: begin
        if (!stream_bit) begin
          state_next = tss_pkg::ST_SW_STANDBY;
        end else if (vs_fall) begin
          state_next = tss_pkg::ST_FRAME;
        end
      end
      tss_pkg::ST_FRAME: begin
        // A stop request only takes effect at the end of a frame
        if (frame_last) begin
          state_next = !stream_bit ? tss_pkg::ST_SW_STANDBY :
            timing_master ? tss_pkg::ST_FRAME :
            tss_pkg::ST_WAIT_VSYNC;
        end
      end
      default: begin
        state_next = tss_pkg::ST_HW_STANDBY;
      end
    endcase
    if (!ext_ok) begin
      state_next = tss_pkg::ST_HW_STANDBY;
    end
  end

  logic new_frame;
  assign new_frame = state_next == tss_pkg::ST_FRAME &&
    (state_reg != tss_pkg::ST_FRAME || frame_last);
  assign cnt_next = (state_next != state_reg || new_frame) ? 16'h0000 :
    (state_reg == tss_pkg::ST_OTP_LOAD && !clk_rise) ? cnt_reg :
    16'(cnt_reg + 16'h0001);

  // Pattern runs only for the pseudo-random pattern number
  logic pat_sel;
  logic pix_valid_next;
  logic led_next;
  assign pat_sel = pat_on_reg[B] &&
    {pat_hi_reg[0], pat_lo_reg} == tss_pkg::PAT_NUM_PN9;
  assign pix_valid_next = state_next == tss_pkg::ST_FRAME &&
    cnt_next >= INTEG_END;
  assign led_next = state_next == tss_pkg::ST_FRAME && cnt_next < INTEG_END &&
    led_ctrl_reg == tss_pkg::LED_CTRL_ON;

  tss_pat_if pat (.clk(core_clk), .rst_n(reset_n));
  assign pat.restart = new_frame;
  assign pat.advance = pix_valid_next && pat_sel;
  tss_prbs9 u_prbs (.pat(pat));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= tss_pkg::ST_HW_STANDBY;
      cnt_reg <= 16'h0000;
      frame_start <= 1'b0;
      frame_active <= 1'b0;
      pix_valid <= 1'b0;
      led_driver_enable <= 1'b0;
      pix_out <= 12'h000;
      illum_out_pos <= 1'b0;
      illum_out_neg <= 1'b0;
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      frame_start <= new_frame;
      frame_active <= state_next == tss_pkg::ST_FRAME;
      pix_valid <= pix_valid_next;
      led_driver_enable <= led_next;
      pix_out <= pat_sel ? {3'h0, pat.data} : pix_in;
      illum_out_pos <= illum_mod;
      illum_out_neg <= illum_reg[B] && !illum_mod;
      reg_rdata <= reg_rd ? rd_mux : reg_rdata;
      reg_rd_valid <= reg_rd;
    end
  end

  assign otp_busy = state_reg == tss_pkg::ST_OTP_LOAD ||
    state_reg == tss_pkg::ST_HW_STANDBY;
  assign chip_standby = state_reg == tss_pkg::ST_CHIP_STANDBY;
  assign sw_standby = state_reg == tss_pkg::ST_SW_STANDBY;
  assign streaming = state_reg == tss_pkg::ST_WAKEUP ||
    state_reg == tss_pkg::ST_WAIT_VSYNC || state_reg == tss_pkg::ST_FRAME;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_wake_done;
    state_reg == tss_pkg::ST_WAKEUP && cnt_reg == WAKE_LAST &&
      timing_master && ext_ok;
  endsequence
  sequence s_vs_seen;
    state_reg == tss_pkg::ST_WAIT_VSYNC && vs_fall && stream_bit && ext_ok;
  endsequence
  sequence s_stop_mid;
    state_reg == tss_pkg::ST_FRAME && !stream_bit && !frame_last && ext_ok;
  endsequence
  load_guard_a: assert property (reg_wr && !wr_allowed && ext_ok
    |=> $stable(standby_reg) && $stable(mode_reg) && $stable(led_ctrl_reg))
    else $error("register changed during load");
  chip_exit_a: assert property (
    state_reg == tss_pkg::ST_CHIP_STANDBY && !standby_bit && ext_ok
    |=> state_reg == tss_pkg::ST_SW_STANDBY)
    else $error("chip standby not left");
  stream_go_a: assert property (
    state_reg == tss_pkg::ST_SW_STANDBY && !standby_bit && stream_bit &&
    ext_ok |=> state_reg == tss_pkg::ST_WAKEUP)
    else $error("streaming not entered");
  wake_frame_a: assert property (s_wake_done |=>
    frame_start && frame_active && !pix_valid)
    else $error("no frame after wakeup");
  first_out_a: assert property (s_vs_seen |=> frame_start)
    else $error("no output after vsync fall");
  stop_drain_a: assert property (s_stop_mid |=>
    state_reg == tss_pkg::ST_FRAME)
    else $error("frame cut short on stop");
  stop_end_a: assert property (frame_last && !stream_bit && ext_ok
    |=> state_reg == tss_pkg::ST_SW_STANDBY ##1 !frame_active)
    else $error("standby not reached after frame");
  illum_cmos_a: assert property (!illum_reg[B] |=> !illum_out_neg)
    else $error("negative pin driven in single-ended mode");
  illum_pair_a: assert property (illum_reg[B] |=>
    illum_out_neg == !$past(illum_mod) && illum_out_pos == $past(illum_mod))
    else $error("differential pair not complementary");
  led_off_a: assert property (led_ctrl_reg == tss_pkg::LED_CTRL_OFF
    |=> !led_driver_enable)
    else $error("LED enable on while disabled");
  led_span_a: assert property (frame_active |->
    pix_valid == (cnt_reg >= INTEG_END) && ($past(led_ctrl_reg) !=
    tss_pkg::LED_CTRL_ON || led_driver_enable == (cnt_reg < INTEG_END)))
    else $error("LED or pixel span wrong in frame");
endmodule // tss_top
`default_nettype wire

// ---- tb/tss_host_model.sv ----
// Host controller model: reset pin, input clock, vsync and register link
`timescale 1ns/1ps
`default_nettype none
module tss_host_model (
  input wire logic core_clk,
  output var logic ext_reset_n,
  output var logic input_clock_pin,
  output var logic vertical_sync_pin,
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic [15:0] reg_addr,
  output var logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  logic clk_run;

  initial begin
    clk_run = 1'b0;
    ext_reset_n = 1'b0;
    input_clock_pin = 1'b0;
    vertical_sync_pin = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
  end

  // Free-running input clock, phase offset from the core clock
  initial begin
    #37;
    forever #100 if (clk_run) input_clock_pin = ~input_clock_pin;
  end

  task automatic power_up();
    repeat (4) @(posedge core_clk);
    clk_run = 1'b1;
    repeat (4000) @(posedge core_clk);
    ext_reset_n <= 1'b1;
  endtask

  // Wait before the first access after the load has finished
  task automatic settle();
    repeat (4000) @(posedge core_clk);
  endtask

  // Standby-off to stream-command wait, shortened to keep runs brief
  task automatic stream_wait();
    repeat (400) @(posedge core_clk);
  endtask

  task automatic power_down();
    @(posedge core_clk);
    ext_reset_n <= 1'b0;
  endtask

  // Released lines show the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [7:0] dat);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~dat;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] dat,
    output logic vld);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge core_clk);
    dat = reg_rdata;
    vld = reg_rd_valid;
  endtask

  task automatic vsync(input logic lvl);
    @(posedge core_clk);
    vertical_sync_pin <= lvl;
  endtask
endmodule // tss_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench of the sensor state sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned W = 20;
  localparam int unsigned N = 20;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic timing_master = 1'b1;
  logic [11:0] pix_in = 12'h000;
  logic illum_mod = 1'b0;
  logic ext_reset_n, input_clock_pin, vertical_sync_pin, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic reg_rd_valid, v, pix_valid, frame_start, frame_active;
  logic led_driver_enable, illum_out_pos, illum_out_neg;
  logic otp_busy, chip_standby, sw_standby, streaming, oka;
  logic [11:0] pix_out;
  logic b [32];
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int k, n, nl, np;
  logic [15:0] addrs [7] = '{tss_pkg::ADDR_CHIP_STANDBY,
    tss_pkg::ADDR_STREAM_MODE, tss_pkg::ADDR_ILLUM_TYPE,
    tss_pkg::ADDR_PAT_NUM_HIGH, tss_pkg::ADDR_PAT_NUM_LOW,
    tss_pkg::ADDR_PAT_ON, tss_pkg::ADDR_LED_CTRL};
  logic [7:0] rsts [7] = '{tss_pkg::RST_CHIP_STANDBY,
    tss_pkg::RST_STREAM_MODE, tss_pkg::RST_ILLUM_TYPE,
    tss_pkg::RST_PAT_NUM_HIGH, tss_pkg::RST_PAT_NUM_LOW,
    tss_pkg::RST_PAT_ON, tss_pkg::RST_LED_CTRL};

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) pix_in <= pix_in + 12'h001;

  tss_top #(.WAKE_CYC(W), .INTEG_CYC(N), .READ_CYC(N)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .ext_reset_n(ext_reset_n),
    .input_clock_pin(input_clock_pin),
    .vertical_sync_pin(vertical_sync_pin), .timing_master(timing_master),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .pix_in(pix_in), .illum_mod(illum_mod),
    .pix_out(pix_out), .pix_valid(pix_valid), .frame_start(frame_start),
    .frame_active(frame_active), .led_driver_enable(led_driver_enable),
    .illum_out_pos(illum_out_pos), .illum_out_neg(illum_out_neg),
    .otp_busy(otp_busy), .chip_standby(chip_standby),
    .sw_standby(sw_standby), .streaming(streaming));

  tss_host_model host (
    .core_clk(core_clk), .ext_reset_n(ext_reset_n),
    .input_clock_pin(input_clock_pin),
    .vertical_sync_pin(vertical_sync_pin), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_start(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
    end while (frame_start !== 1'b1 && cnt < lim);
  endtask

  task automatic wait_idle();
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (sw_standby !== 1'b1 && k < 3 * N);
  endtask

  task automatic t_load();
    host.power_up();
    repeat (6) @(negedge core_clk);
    chk(otp_busy, 1'b1);
    host.wr(tss_pkg::ADDR_CHIP_STANDBY, 8'h00);
    k = 0;
    while (otp_busy !== 1'b0 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    chk(otp_busy, 1'b0);
    host.settle();
    foreach (addrs[i]) begin
      host.rd(addrs[i], d, v);
      chk({v, d}, {1'b1, rsts[i]});
    end
    host.rd(16'h2000, d, v);
    chk(d, 8'h00);
  endtask

  task automatic t_standby();
    for (int i = 0; i < 3; i++) begin
      host.wr(tss_pkg::ADDR_CHIP_STANDBY, {7'h00, i == 1});
      repeat (2) @(negedge core_clk);
      chk({chip_standby, sw_standby}, (i == 1) ? 2'b10 : 2'b01);
    end
  endtask

  task automatic t_master();
    host.wr(tss_pkg::ADDR_LED_CTRL, tss_pkg::LED_CTRL_ON);
    host.stream_wait();
    host.wr(tss_pkg::ADDR_STREAM_MODE, 8'h01);
    wait_start(W + 10, k);
    chk(k >= W + 1 && k <= W + 3, 1'b1);
    nl = 0;
    np = 0;
    for (int i = 0; i < 2 * N; i++) begin
      nl += (led_driver_enable === 1'b1);
      np += (pix_valid === 1'b1);
      chk({frame_start, frame_active}, {i == 0, 1'b1});
      if (pix_valid === 1'b1) chk(pix_out, pix_in - 12'h001);
      @(negedge core_clk);
    end
    chk(nl, N);
    chk(np, N);
    wait_start(5, k);
    repeat (4) @(negedge core_clk);
    host.wr(tss_pkg::ADDR_STREAM_MODE, 8'h00);
    np = 0;
    k = 0;
    @(negedge core_clk);
    while (frame_active === 1'b1 && k < 3 * N) begin
      np += (pix_valid === 1'b1);
      @(negedge core_clk);
      k++;
    end
    chk(np, N);
    repeat (2) @(negedge core_clk);
    chk({streaming, sw_standby}, 2'b01);
  endtask

  task automatic t_slave();
    @(posedge core_clk);
    timing_master <= 1'b0;
    host.wr(tss_pkg::ADDR_LED_CTRL, tss_pkg::LED_CTRL_OFF);
    host.wr(tss_pkg::ADDR_STREAM_MODE, 8'h01);
    repeat (2 * W) @(negedge core_clk);
    chk({streaming, frame_active}, 2'b10);
    host.vsync(1'b0);
    wait_start(8, k);
    chk(frame_start, 1'b1);
    host.vsync(1'b1);
    for (int i = 0; i < 2 * N; i++) begin
      chk(led_driver_enable, 1'b0);
      @(negedge core_clk);
    end
    host.wr(tss_pkg::ADDR_STREAM_MODE, 8'h00);
    repeat (2) @(negedge core_clk);
    chk(sw_standby, 1'b1);
  endtask

  task automatic t_illum();
    for (int t = 0; t < 2; t++) begin
      host.wr(tss_pkg::ADDR_ILLUM_TYPE, {7'h00, t[0]});
      for (int m = 0; m < 2; m++) begin
        @(posedge core_clk);
        illum_mod <= m[0];
        repeat (2) @(negedge core_clk);
        chk({illum_out_pos, illum_out_neg}, {m[0], t[0] & ~m[0]});
      end
    end
  endtask

  task automatic t_pattern();
    host.wr(tss_pkg::ADDR_PAT_NUM_HIGH, 8'h00);
    host.wr(tss_pkg::ADDR_PAT_NUM_LOW, 8'h04);
    host.wr(tss_pkg::ADDR_PAT_ON, 8'h01);
    @(posedge core_clk);
    timing_master <= 1'b1;
    host.wr(tss_pkg::ADDR_STREAM_MODE, 8'h01);
    wait_start(W + 10, k);
    n = 0;
    for (int i = 0; i < 2 * N; i++) begin
      if (pix_valid === 1'b1 && n < 32) begin
        b[n] = pix_out[0];
        n++;
        chk({pix_out[11:9], |pix_out[8:0]}, 4'h1);
      end
      @(negedge core_clk);
    end
    oka = 1'b1;
    for (int i = 9; i < n; i++) begin
      oka &= (b[i] === (b[i - 9] ^ b[i - 5]));
    end
    chk({n == N, oka}, 2'b11);
    host.wr(tss_pkg::ADDR_STREAM_MODE, 8'h00);
    wait_idle();
    chk(sw_standby, 1'b1);
    host.power_down();
    repeat (5) @(negedge core_clk);
    chk({otp_busy, streaming}, 2'b10);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    t_load();
    t_standby();
    t_master();
    t_slave();
    t_illum();
    t_pattern();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
